// File: core/eppm_regs.svh
// register offsets, field positions, reset values and counts for the path overhead monitor
`ifndef EPPM_REGS_SVH
`define EPPM_REGS_SVH

// word offsets on the wishbone bus (byte addresses)
`define EPPM_ADR_CTRL     8'h00
`define EPPM_ADR_STATUS   8'h04
`define EPPM_ADR_DEGTHR   8'h08
`define EPPM_ADR_DEGM     8'h0C
`define EPPM_ADR_NEAR_BC  8'h10
`define EPPM_ADR_FAR_BC   8'h14
`define EPPM_ADR_SECONDS  8'h18
`define EPPM_ADR_EXP_TR0  8'h20
`define EPPM_ADR_ACC_TR0  8'h30

// control register bits
`define EPPM_CTRL_MON     0
`define EPPM_CTRL_TIMOFF  1
`define EPPM_CTRL_SSFREP  2
`define EPPM_CTRL_RDIREP  3
`define EPPM_CTRL_RESET   4'h0

// maintenance byte fields, bit 1 being the msb on the line
`define EPPM_MA_RDI       7
`define EPPM_MA_REI       6
`define EPPM_MA_LBL_HI    5
`define EPPM_MA_LBL_LO    3
`define EPPM_LBL_AIS      3'h7
`define EPPM_LBL_UNEQ     3'h0

// persistence and trace figures
`define EPPM_PERSIST      3'h5
`define EPPM_TRACE_LEN    16
`define EPPM_TRACE_SAME   2'h2
`define EPPM_DEGTHR_RESET 16'h0001
`define EPPM_DEGM_RESET   4'h3

`endif

// File: core/eppm_pkg.sv
// types for the path overhead monitor
package eppm_pkg;

    // incoming frame byte stream from the upstream framer
    typedef struct packed {
        logic       start;
        logic       valid;
        logic [7:0] data;
    } eppm_stream_t;

    // fault causes towards management
    typedef struct packed {
        logic uneq;
        logic tim;
        logic deg;
        logic rdi;
        logic ssf;
    } eppm_cause_t;

    // whole state of the monitor
    typedef struct packed {
        logic             ack;
        logic [31:0]      rdat;
        logic [3:0]       ctrl;
        logic [15:0]      degthr;
        logic [3:0]       degm;
        logic [15:0][7:0] exp_tr;
        logic [15:0][7:0] acc_tr;
        logic [15:0][7:0] cap_tr;
        logic [15:0][7:0] last_tr;
        logic [3:0]       tidx;
        logic             tsync;
        logic [1:0]       tsame;
        logic [9:0]       pos;
        logic [7:0]       par;
        logic [7:0]       ppar;
        logic             have_prev;
        logic             ais;
        logic [2:0]       aisc;
        logic             uneq;
        logic [2:0]       uneqc;
        logic             rdi;
        logic [2:0]       rdic;
        logic             tim;
        logic             deg;
        logic [3:0]       degc;
        logic [15:0]      sec_err;
        logic [15:0]      nbc;
        logic [15:0]      fbc;
        logic             nds;
        logic             fds;
        logic [15:0]      out_nbc;
        logic [15:0]      out_fbc;
        logic             out_nds;
        logic             out_fds;
        logic             tsf;
        logic             tsd;
        eppm_cause_t      cause;
    } eppm_state_t;

endpackage : eppm_pkg

// File: core/eppm_monitor.sv
// non-intrusive path overhead monitor with wishbone management registers
`timescale 1ns/1ps
`include "eppm_regs.svh"

// Overview of operation
// - per-bit even parity of previous frame checked
// - assemble sixteen-byte trace, show accepted value
// - only framed sixteen-byte trace mode supported
// - maintenance bit1 remote defect, bit2 remote error
// - remote defect bit one means far defect
// - each remote error bit counts far block
// - label bits three to five extracted
// - five label-111 frames raise alarm signal defect
// - five other-label frames clear alarm defect
// - server fail or alarm suppresses other detectors
// - mismatch detection can be switched off
// - trail fail and degraded outputs from defects
// - unequipped cause; mismatch cause without unequipped
// - degraded cause only without unequipped, mismatch
// - far defect cause gated and report enabled
// - server fail cause when reporting enabled
// - server fail reporting off after reset
// - far defect reporting off after reset
// - four performance outputs from defects, counts
// - overhead of this frame judges previous
module eppm_monitor #(
    parameter int FRAME_BYTES = 531,
    parameter int POS_EM = 0,
    parameter int POS_TR = 59,
    parameter int POS_MA = 118
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire eppm_pkg::eppm_stream_t stream_i,
    input wire logic server_fail_in_i,
    input wire logic equipment_defect_i,
    input wire logic one_sec_pulse_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic trail_fail_out_o,
    output logic trail_degraded_out_o,
    output eppm_pkg::eppm_cause_t cause_o,
    output logic near_defect_second_o,
    output logic far_defect_second_o,
    output logic [15:0] near_block_count_o,
    output logic [15:0] far_block_count_o
);

    eppm_pkg::eppm_state_t st_r;
    eppm_pkg::eppm_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////////////////
    // helpers

    // n-frame persistence: flips the defect after enough frames disagree with it
    function automatic logic [3:0] persist(input logic cur, input logic hit,
                                           input logic [2:0] cnt);
        logic [2:0] c;
        c = cnt + 3'h1;
        if (hit == cur) begin
            persist = {cur, 3'h0};
        end else if (c == `EPPM_PERSIST) begin
            persist = {hit, 3'h0};
        end else begin
            persist = {cur, c};
        end
    endfunction : persist

    // byte-lane write of one word
    function automatic logic [31:0] lane_wr(input logic [31:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        lane_wr = r;
    endfunction : lane_wr

    // saturating increment of a count
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction : sat_inc

    ////////////////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic [7:0] b;
        logic hit_em;
        logic hit_tr;
        logic hit_ma;
        logic supp;
        logic mon;
        logic nerr;
        logic ferr;
        logic done;
        logic bad;
        logic [3:0] p;
        logic [2:0] lbl;
        logic [15:0][7:0] newcap;
        logic [3:0] widx;
        b = stream_i.data;
        hit_em = 1'b0;
        hit_tr = 1'b0;
        hit_ma = 1'b0;
        nerr = 1'b0;
        ferr = 1'b0;
        done = 1'b0;
        bad = 1'b0;
        p = 4'h0;
        supp = 1'b0;
        mon = 1'b0;
        lbl = b[`EPPM_MA_LBL_HI:`EPPM_MA_LBL_LO];
        newcap = st_r.cap_tr;
        widx = 4'h0;
        st_nxt = st_r;
        st_nxt.ack = 1'b0;

        // frame position and running parity
        if (stream_i.valid) begin
            if (stream_i.start) begin
                st_nxt.ppar = st_r.par;
                st_nxt.have_prev = (st_r.pos != 10'h000) || st_r.have_prev;
                st_nxt.par = b;
                st_nxt.pos = 10'h001;
                hit_em = (POS_EM == 0);
            end else begin
                st_nxt.par = st_r.par ^ b;
                if (st_r.pos != FRAME_BYTES[9:0]) begin
                    st_nxt.pos = st_r.pos + 10'h001;
                end
                hit_em = (st_r.pos == POS_EM[9:0]);
                hit_tr = (st_r.pos == POS_TR[9:0]);
                hit_ma = (st_r.pos == POS_MA[9:0]);
            end
        end

        supp = server_fail_in_i | st_r.ais;
        mon = st_r.ctrl[`EPPM_CTRL_MON];

        // parity byte against parity of the previous frame
        if (hit_em && st_r.have_prev) begin
            nerr = ((stream_i.start ? st_r.par : st_r.ppar) ^ b) != 8'h00;
        end

        // maintenance byte: far-end bits and label
        if (hit_ma) begin
            ferr = b[`EPPM_MA_REI];
            p = persist(st_r.ais, lbl == `EPPM_LBL_AIS, st_r.aisc);
            st_nxt.ais = p[3];
            st_nxt.aisc = p[2:0];
            p = persist(st_r.uneq, lbl == `EPPM_LBL_UNEQ, st_r.uneqc);
            st_nxt.uneq = p[3];
            st_nxt.uneqc = p[2:0];
            p = persist(st_r.rdi, b[`EPPM_MA_RDI], st_r.rdic);
            st_nxt.rdi = p[3];
            st_nxt.rdic = p[2:0];
        end

        // framed trace capture: msb set marks the first byte
        if (hit_tr) begin
            if (b[7]) begin
                newcap[0] = b;
                st_nxt.tidx = 4'h1;
                st_nxt.tsync = 1'b1;
            end else if (st_r.tsync && st_r.tidx != 4'h0) begin
                widx = st_r.tidx;
                newcap[widx] = b;
                st_nxt.tidx = st_r.tidx + 4'h1;
                done = (st_r.tidx == 4'hF);
            end else begin
                st_nxt.tsync = 1'b0;
            end
            st_nxt.cap_tr = newcap;
        end
        // accept after three identical strings in a row
        if (done) begin
            st_nxt.last_tr = newcap;
            if (newcap == st_r.last_tr) begin
                if (st_r.tsame + 2'h1 == `EPPM_TRACE_SAME) begin
                    st_nxt.acc_tr = newcap;
                end else begin
                    st_nxt.tsame = st_r.tsame + 2'h1;
                end
            end else begin
                st_nxt.tsame = 2'h0;
            end
        end

        // mismatch of accepted against expected trace
        st_nxt.tim = !st_r.ctrl[`EPPM_CTRL_TIMOFF] && !supp
                     && (st_r.acc_tr != st_r.exp_tr);

        // degraded: error count per second over a run of seconds
        if (nerr) begin
            st_nxt.sec_err = sat_inc(st_r.sec_err);
        end
        // judge the closing second; an error on the boundary opens the next one
        if (one_sec_pulse_i) begin
            bad = st_r.sec_err >= st_r.degthr;
            st_nxt.sec_err = {15'h0000, nerr};
            if (bad == st_r.deg) begin
                st_nxt.degc = 4'h0;
            end else if (st_r.degc + 4'h1 >= st_r.degm) begin
                st_nxt.deg = bad;
                st_nxt.degc = 4'h0;
            end else begin
                st_nxt.degc = st_r.degc + 4'h1;
            end
        end

        // detectors held clear under server fail or alarm signal
        if (supp) begin
            st_nxt.uneq = 1'b0;
            st_nxt.uneqc = 3'h0;
            st_nxt.rdi = 1'b0;
            st_nxt.rdic = 3'h0;
            st_nxt.deg = 1'b0;
            st_nxt.degc = 4'h0;
            st_nxt.tim = 1'b0;
        end

        // consequent actions
        st_nxt.tsf = server_fail_in_i | st_r.ais | st_r.uneq | st_r.tim;
        st_nxt.tsd = st_r.deg;

        // fault cause correlation
        st_nxt.cause.uneq = mon & st_r.uneq;
        st_nxt.cause.tim = mon & st_r.tim & ~st_r.uneq;
        st_nxt.cause.deg = mon & st_r.deg & ~st_r.uneq & ~st_r.tim;
        st_nxt.cause.rdi = mon & st_r.rdi & ~st_r.tim & ~st_r.uneq
                           & st_r.ctrl[`EPPM_CTRL_RDIREP];
        st_nxt.cause.ssf = mon & (server_fail_in_i | st_r.ais)
                           & st_r.ctrl[`EPPM_CTRL_SSFREP];

        // one-second performance gathering
        if (nerr) begin
            st_nxt.nbc = sat_inc(st_r.nbc);
        end
        if (ferr) begin
            st_nxt.fbc = sat_inc(st_r.fbc);
        end
        st_nxt.nds = st_r.nds | st_r.tsf | equipment_defect_i;
        st_nxt.fds = st_r.fds | st_r.rdi;
        if (one_sec_pulse_i) begin
            st_nxt.out_nbc = st_r.nbc;
            st_nxt.out_fbc = st_r.fbc;
            st_nxt.out_nds = st_r.nds;
            st_nxt.out_fds = st_r.fds;
            st_nxt.nbc = {15'h0000, nerr};
            st_nxt.fbc = {15'h0000, ferr};
            st_nxt.nds = st_r.tsf | equipment_defect_i;
            st_nxt.fds = st_r.rdi;
        end

        // wishbone slave: one wait state, ack for one cycle
        if (wb_cyc_i && wb_stb_i && !st_r.ack) begin
            st_nxt.ack = 1'b1;
            st_nxt.rdat = 32'h0000_0000;
            if (wb_we_i) begin
                case (wb_adr_i)
                    `EPPM_ADR_CTRL: begin
                        if (wb_sel_i[0]) begin
                            st_nxt.ctrl = wb_dat_i[3:0];
                        end
                    end
                    `EPPM_ADR_DEGTHR: begin
                        st_nxt.degthr = 16'(lane_wr({16'h0000, st_r.degthr}, wb_dat_i,
                                                    wb_sel_i)); // lower half only
                    end
                    `EPPM_ADR_DEGM: begin
                        if (wb_sel_i[0]) begin
                            st_nxt.degm = wb_dat_i[3:0];
                        end
                    end
                    default: begin
                        if (wb_adr_i[7:4] == `EPPM_ADR_EXP_TR0 >> 4) begin
                            st_nxt.exp_tr[wb_adr_i[3:2]*4 +: 4] =
                                lane_wr(st_r.exp_tr[wb_adr_i[3:2]*4 +: 4], wb_dat_i,
                                        wb_sel_i);
                        end
                    end
                endcase
            end else begin
                case (wb_adr_i)
                    `EPPM_ADR_CTRL: st_nxt.rdat = {28'h000_0000, st_r.ctrl};
                    `EPPM_ADR_STATUS: st_nxt.rdat = {20'h0_0000, st_r.tsd, st_r.tsf,
                                                    st_r.ais, st_r.uneq, st_r.tim,
                                                    st_r.deg, st_r.rdi, st_r.cause};
                    `EPPM_ADR_DEGTHR: st_nxt.rdat = {16'h0000, st_r.degthr};
                    `EPPM_ADR_DEGM: st_nxt.rdat = {28'h000_0000, st_r.degm};
                    `EPPM_ADR_NEAR_BC: st_nxt.rdat = {16'h0000, st_r.out_nbc};
                    `EPPM_ADR_FAR_BC: st_nxt.rdat = {16'h0000, st_r.out_fbc};
                    `EPPM_ADR_SECONDS: st_nxt.rdat = {30'h0000_0000, st_r.out_fds,
                                                     st_r.out_nds};
                    default: begin
                        if (wb_adr_i[7:4] == `EPPM_ADR_EXP_TR0 >> 4) begin
                            st_nxt.rdat = st_r.exp_tr[wb_adr_i[3:2]*4 +: 4];
                        end else if (wb_adr_i[7:4] == `EPPM_ADR_ACC_TR0 >> 4) begin
                            st_nxt.rdat = st_r.acc_tr[wb_adr_i[3:2]*4 +: 4];
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.ctrl <= `EPPM_CTRL_RESET;
            st_r.degthr <= `EPPM_DEGTHR_RESET;
            st_r.degm <= `EPPM_DEGM_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign wb_dat_o = st_r.rdat;
    assign wb_ack_o = st_r.ack;
    assign trail_fail_out_o = st_r.tsf;
    assign trail_degraded_out_o = st_r.tsd;
    assign cause_o = st_r.cause;
    assign near_defect_second_o = st_r.out_nds;
    assign far_defect_second_o = st_r.out_fds;
    assign near_block_count_o = st_r.out_nbc;
    assign far_block_count_o = st_r.out_fbc;

endmodule : eppm_monitor

// File: tb/eppm_framer.sv
// upstream framer model feeding whole frames to the monitor
`timescale 1ns/1ps
module eppm_framer #(
    parameter int FRAME_BYTES = 128,
    parameter int POS_TR = 59,
    parameter int POS_MA = 118
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] maint_i,
    input wire logic par_err_i,
    output eppm_pkg::eppm_stream_t stream_o
);
    int seed = 68996;
    logic [9:0] pos_r;
    logic [3:0] tidx_r;
    logic [7:0] acc_r;
    logic [7:0] ma_r;
    logic [7:0] rnd_r;
    logic [7:0] b;

    ////////////////////////////////////////////////////////////////////////////
    // byte for the current position: parity byte leads, overhead bytes fixed
    always_comb begin
        if (pos_r == 10'h000) begin
            b = acc_r ^ {7'h00, par_err_i};
        end else if (pos_r == POS_TR) begin
            b = (tidx_r == 4'h0) ? 8'h80 : {4'h0, tidx_r};
        end else if (pos_r == POS_MA) begin
            b = ma_r;
        end else begin
            b = rnd_r;
        end
    end

    // one byte a cycle; maintenance byte latched once per frame
    always @(posedge clk_i) begin
        if (rst_i) begin
            pos_r <= 10'h000;
            tidx_r <= 4'h0;
            acc_r <= 8'h00;
            ma_r <= 8'h00;
            rnd_r <= 8'h00;
            stream_o <= '0;
        end else begin
            if (pos_r == 10'h000) begin
                ma_r <= maint_i;
            end
            if (pos_r == POS_TR) begin
                tidx_r <= tidx_r + 4'h1;
            end
            rnd_r <= 8'($random(seed));
            acc_r <= (pos_r == 10'h000) ? b : acc_r ^ b;
            stream_o <= {pos_r == 10'h000, 1'b1, b};
            pos_r <= (pos_r == 10'(FRAME_BYTES - 1)) ? 10'h000 : pos_r + 10'h001;
        end
    end
endmodule : eppm_framer

// File: tb/eppm_monitor_chk.sv
// concurrent checks on the path overhead monitor ports
`timescale 1ns/1ps
module eppm_monitor_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic server_fail_in_i,
    input wire logic one_sec_pulse_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic trail_fail_out_o,
    input wire eppm_pkg::eppm_cause_t cause_o,
    input wire logic near_defect_second_o,
    input wire logic far_defect_second_o,
    input wire logic [15:0] near_block_count_o,
    input wire logic [15:0] far_block_count_o
);
    logic wrote_r;
    logic wrote_nxt;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////
    // remembers any management write since reset
    always_comb begin
        wrote_nxt = wrote_r | (wb_ack_o & wb_we_i);
    end
    always_ff @(posedge clk_i) begin
        wrote_r <= rst_i ? 1'b0 : wrote_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // multi-step behaviours
    sequence wb_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_pulse_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence fail_held_s;
        server_fail_in_i [*5];
    endsequence

    wb_ack_pulse_a: assert property (wb_req_s |=> ack_pulse_s)
        else $error("ack timing wrong");
    write_reads_zero_a: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0000_0000)
        else $error("write returned data");
    fail_to_tsf_a: assert property (server_fail_in_i |-> ##[1:2] trail_fail_out_o)
        else $error("server fail not on trail fail");
    reset_quiet_a: assert property (!wrote_r |-> cause_o == 5'h00)
        else $error("cause without setup");
    tim_gated_a: assert property (cause_o.tim |-> !cause_o.uneq)
        else $error("mismatch cause with unequipped");
    deg_gated_a: assert property (cause_o.deg |-> !cause_o.uneq && !cause_o.tim)
        else $error("degraded cause not gated");
    rdi_gated_a: assert property (cause_o.rdi |-> !cause_o.uneq && !cause_o.tim)
        else $error("far defect cause not gated");
    fail_causes_a: assert property (cause_o.uneq || cause_o.tim || cause_o.ssf
        |-> trail_fail_out_o)
        else $error("fail cause without trail fail");
    suppress_a: assert property (fail_held_s |-> !cause_o.rdi && !cause_o.deg
        && !cause_o.uneq && !cause_o.tim)
        else $error("cause not suppressed");
    perf_latch_a: assert property (!$past(rst_i) && !$stable({near_block_count_o,
        far_block_count_o, near_defect_second_o, far_defect_second_o})
        |-> $past(one_sec_pulse_i))
        else $error("perf outputs moved off pulse");
endmodule : eppm_monitor_chk

bind eppm_monitor eppm_monitor_chk eppm_monitor_chk_inst (
    .clk_i(clk_i), .rst_i(rst_i), .server_fail_in_i(server_fail_in_i),
    .one_sec_pulse_i(one_sec_pulse_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .trail_fail_out_o(trail_fail_out_o), .cause_o(cause_o),
    .near_defect_second_o(near_defect_second_o), .far_defect_second_o(far_defect_second_o),
    .near_block_count_o(near_block_count_o), .far_block_count_o(far_block_count_o));

// File: tb/eppm_monitor_tb_top.sv
// self-checking bench for the path overhead monitor
`timescale 1ns/1ps
`include "eppm_regs.svh"
module eppm_monitor_tb_top;
    localparam int FB = 128;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sf = 1'b0;
    logic pulse = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [7:0] maint = 8'h08;
    logic perr = 1'b0;
    logic eqd = 1'b0;
    logic snap = 1'b0;
    logic [31:0] rdat;
    logic ack, tsf, tsd, nds, fds;
    logic [15:0] nbc, fbc;
    eppm_pkg::eppm_cause_t cause;
    eppm_pkg::eppm_stream_t strm;
    logic [31:0] rd_q[$];
    logic [40:0] port_q[$];
    int fail_count = 0;
    int checks = 0;

    eppm_framer #(.FRAME_BYTES(FB)) eppm_framer_inst (.clk_i(clk_i), .rst_i(rst_i),
        .maint_i(maint), .par_err_i(perr), .stream_o(strm));
    eppm_monitor #(.FRAME_BYTES(FB)) eppm_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
        .stream_i(strm), .server_fail_in_i(sf), .equipment_defect_i(eqd),
        .one_sec_pulse_i(pulse), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .trail_fail_out_o(tsf), .trail_degraded_out_o(tsd),
        .cause_o(cause), .near_defect_second_o(nds), .far_defect_second_o(fds),
        .near_block_count_o(nbc), .far_block_count_o(fbc));

    // 200 MHz clock
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_rd

    task automatic cmp_port(input logic [40:0] got, input logic [40:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_port

    // classic single wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        wb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic expect_ports(input logic t, input logic d, input logic [4:0] c,
        input logic n, input logic f, input logic [15:0] nb, input logic [15:0] fb);
        port_q.push_back({t, d, c, n, f, nb, fb});
        snap <= 1'b1;
        @(posedge clk_i);
        snap <= 1'b0;
    endtask : expect_ports

    task automatic frames(input int n);
        repeat (n * FB) @(posedge clk_i);
    endtask : frames

    task automatic tick();
        pulse <= 1'b1;
        @(posedge clk_i);
        pulse <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : tick

    ////////////////////////////////////////////////////////////////////////////
    // result watcher: oldest note against what appears
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0) begin
            cmp_rd(rdat, rd_q.pop_front());
        end
        if (snap === 1'b1) begin
            cmp_port({tsf, tsd, cause, nds, fds, nbc, fbc}, port_q.pop_front());
        end
    end

    // main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`EPPM_ADR_CTRL, 32'h0000_0000);
        rd(8'hFC, 32'h0000_0000);
        wb(1'b1, `EPPM_ADR_CTRL, 32'h0000_000F);
        rd(`EPPM_ADR_CTRL, 32'h0000_000F);
        frames(2);
        tick();
        perr <= 1'b1;
        maint <= 8'h48;
        frames(3);
        perr <= 1'b0;
        maint <= 8'h08;
        frames(2);
        tick();
        expect_ports(0, 0, 5'h00, 0, 0, 16'h0003, 16'h0003);
        maint <= 8'h38;
        frames(7);
        expect_ports(1, 0, 5'h01, 0, 0, 16'h0003, 16'h0003);
        maint <= 8'h08;
        frames(7);
        expect_ports(0, 0, 5'h00, 0, 0, 16'h0003, 16'h0003);
        maint <= 8'h88;
        frames(7);
        expect_ports(0, 0, 5'h02, 0, 0, 16'h0003, 16'h0003);
        sf <= 1'b1;
        repeat (8) @(posedge clk_i);
        expect_ports(1, 0, 5'h01, 0, 0, 16'h0003, 16'h0003);
        sf <= 1'b0;
        maint <= 8'h08;
        frames(7);
        tick();
        expect_ports(0, 0, 5'h00, 1, 1, 16'h0000, 16'h0000);
        // equipment defect alone marks a near-end defect second
        eqd <= 1'b1;
        @(posedge clk_i);
        eqd <= 1'b0;
        tick();
        expect_ports(0, 0, 5'h00, 1, 0, 16'h0000, 16'h0000);
        // three seconds with one errored block each raise the degraded defect
        repeat (3) begin
            perr <= 1'b1;
            frames(1);
            perr <= 1'b0;
            frames(1);
            tick();
        end
        expect_ports(0, 1, 5'h04, 0, 0, 16'h0001, 16'h0000);
        frames(40);
        rd(`EPPM_ADR_ACC_TR0, 32'h0302_0180);
        wb(1'b1, `EPPM_ADR_CTRL, 32'h0000_000D);
        frames(1);
        expect_ports(1, 1, 5'h08, 0, 0, 16'h0001, 16'h0000);
        report_and_stop();
    end

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        report_and_stop();
    end
endmodule : eppm_monitor_tb_top
